// File: common/lvd_cfg.svh
`ifndef LVD_CFG_SVH
`define LVD_CFG_SVH

// =====================================================================
// Register map, byte addresses on the register bus.
`define LVD_ADR_W          5
`define LVD_ADR_CTRL       5'h00
`define LVD_ADR_LEVEL      5'h04
`define LVD_ADR_IRQ        5'h08
`define LVD_ADR_MASK       5'h0c
`define LVD_ADR_CAUSE      5'h10

// =====================================================================
// Field positions.
`define LVD_BIT_EN         7
`define LVD_BIT_SRC        2
`define LVD_BIT_MODE       1
`define LVD_BIT_BELOW      0
`define LVD_LEVEL_MSB      3
`define LVD_BIT_IRQ        1
`define LVD_BIT_MASK       1
`define LVD_BIT_CAUSE      0
`define LVD_BIT_DS_OFF     0

// =====================================================================
// Reset values and zero fills.
`define LVD_LEVEL_DEFAULT  4'he
`define LVD_LEVEL_RESET    4'h0
`define LVD_BYTE_ZERO      8'h00
`define LVD_PAD_ZERO       24'h000000

// =====================================================================
// Timing, in microseconds and megahertz.
`define LVD_MIN_PULSE_US   200
`define LVD_CLK_MHZ        50

`endif

// File: common/lvd_det_if.sv
`timescale 1ns/1ps
`default_nettype none
// Carries the comparator level into the filter and the debounced result back.
interface lvd_det_if;
	logic enable;
	logic raw_below;
	logic below;
	logic changed;

	modport ctrl (output enable, output raw_below, input below, input changed);
	modport filt (input enable, input raw_below, output below, output changed);
endinterface
`default_nettype wire

// File: common/lvd_pkg.sv
`default_nettype none
package lvd_pkg;

	// One register byte as software sees it.
	typedef logic [7:0] lvd_byte_t;

	// Filter state: idle while detection is off, else the debounced side.
	typedef enum logic [1:0] {LVD_IDLE, LVD_ABOVE, LVD_BELOW} lvd_filt_state_t;

endpackage
`default_nettype wire

// File: verification/low_voltage_detect_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "lvd_cfg.svh"
module low_voltage_detect_control_tb;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [4:0]  adr = 5'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o;
	logic        ack;
	logic        strap = 1'b0;
	logic        en;
	logic        src;
	logic [3:0]  lvl;
	logic        irq;
	logic        rstq;
	logic        cmp_s;
	logic        cmp_e;
	logic [3:0]  supply_lvl = 4'hf;
	logic        ext_low = 1'b0;
	int          err_total = 0;
	int          checks = 0;

	// ====================================
	// Clock, design and comparator model
	// The clock toggles each 10 ns half period of a 20 ns cycle.
	always #10 clk = ~clk;

	lvd_ctrl #(.MIN_PULSE_CYC(8)) u_lvd_ctrl
	(
		.CORE_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o),
		.WB_ACK_O(ack), .CMP_SUPPLY_BELOW(cmp_s), .CMP_EXT_BELOW(cmp_e),
		.DEFAULT_START_DISABLE(strap), .DETECT_ENABLE(en), .SOURCE_SELECT(src),
		.LEVEL_CODE(lvl), .DETECT_IRQ(irq), .LV_RESET_REQ(rstq)
	);

	lvd_cmp_model u_lvd_cmp_model
	(
		.detect_enable(en), .level_code(lvl), .supply_lvl(supply_lvl),
		.ext_low(ext_low), .cmp_supply_below(cmp_s), .cmp_ext_below(cmp_e)
	);

	// ====================================
	// Tasks
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// One classic cycle; only the watchdog ends a wait that never sees ack.
	task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d,
		output logic [31:0] q);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'h1;
		dat_i <= {24'h0, d};
		do
			@(posedge clk);
		while (ack !== 1'b1);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		// One idle edge later ack must be gone and a write is visible outside.
		@(posedge clk);
		chk("bus ack", {31'h0, ack}, 32'h0);
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask

	task automatic rd(input string nm, input logic [4:0] a, input logic [31:0] exp);
		logic [31:0] q;
		wb(1'b0, a, 8'h00, q);
		chk(nm, q, exp);
	endtask

	// The strap settles two edges before reset so its synchroniser is full.
	task automatic do_reset(input logic s);
		@(posedge clk);
		strap <= s;
		repeat (2) @(posedge clk);
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
	endtask

	task automatic settle;
		repeat (20) @(posedge clk);
	endtask

	// ====================================
	// Watchdog, far beyond the roughly 400 cycles the tests need
	initial
	begin
		repeat (6000) @(posedge clk);
		err_total++;
		complete_run();
	end

	// ====================================
	// Test sequence
	initial
	begin
		do_reset(1'b0);
		chk("enable out", {31'h0, en}, 32'h1);
		chk("source out", {31'h0, src}, 32'h0);
		chk("level out", {28'h0, lvl}, 32'he);
		rd("control", `LVD_ADR_CTRL, 32'h82);
		rd("level", `LVD_ADR_LEVEL, 32'h0e);
		rd("mask", `LVD_ADR_MASK, 32'h02);
		rd("request", `LVD_ADR_IRQ, 32'h00);
		$display("test default_start done");
		// A long low supply in reset mode holds the reset request.
		supply_lvl <= 4'h0;
		settle();
		chk("reset req", {31'h0, rstq}, 32'h1);
		rd("control", `LVD_ADR_CTRL, 32'h83);
		rd("cause", `LVD_ADR_CAUSE, 32'h01);
		supply_lvl <= 4'hf;
		settle();
		chk("reset req", {31'h0, rstq}, 32'h0);
		rd("control", `LVD_ADR_CTRL, 32'h82);
		// The read under an active request left the cause set; this one clears it.
		rd("cause", `LVD_ADR_CAUSE, 32'h01);
		rd("cause", `LVD_ADR_CAUSE, 32'h00);
		wr(`LVD_ADR_CTRL, 8'h80);
		wr(`LVD_ADR_MASK, 8'h00);
		wr(`LVD_ADR_CTRL, 8'h00);
		chk("enable out", {31'h0, en}, 32'h0);
		do_reset(1'b0);
		chk("enable out", {31'h0, en}, 32'h1);
		rd("mask", `LVD_ADR_MASK, 32'h02);
		$display("test reset_mode done");
		// Interrupt mode after a plain start.
		do_reset(1'b1);
		chk("enable out", {31'h0, en}, 32'h0);
		rd("control", `LVD_ADR_CTRL, 32'h00);
		rd("level", `LVD_ADR_LEVEL, 32'h00);
		wr(`LVD_ADR_MASK, 8'h02);
		wr(`LVD_ADR_LEVEL, 8'h05);
		chk("level out", {28'h0, lvl}, 32'h5);
		wr(`LVD_ADR_CTRL, 8'h80);
		repeat (30) @(posedge clk);
		rd("control", `LVD_ADR_CTRL, 32'h80);
		wr(`LVD_ADR_IRQ, 8'h00);
		wr(`LVD_ADR_MASK, 8'h00);
		supply_lvl <= 4'h2;
		settle();
		chk("irq out", {31'h0, irq}, 32'h1);
		chk("reset req", {31'h0, rstq}, 32'h0);
		rd("request", `LVD_ADR_IRQ, 32'h02);
		rd("control", `LVD_ADR_CTRL, 32'h81);
		wr(`LVD_ADR_IRQ, 8'h00);
		repeat (3) @(posedge clk);
		chk("irq out", {31'h0, irq}, 32'h0);
		supply_lvl <= 4'hf;
		settle();
		chk("irq out", {31'h0, irq}, 32'h1);
		wr(`LVD_ADR_IRQ, 8'h00);
		wr(`LVD_ADR_LEVEL, 8'h06);
		rd("request", `LVD_ADR_IRQ, 32'h02);
		wr(`LVD_ADR_IRQ, 8'h00);
		// A dip shorter than the minimum width is ignored.
		supply_lvl <= 4'h2;
		repeat (4) @(posedge clk);
		supply_lvl <= 4'hf;
		settle();
		rd("request", `LVD_ADR_IRQ, 32'h00);
		$display("test irq_mode done");
		// Pin source, then stop while the pin is low.
		wr(`LVD_ADR_CTRL, 8'h84);
		supply_lvl <= 4'h0;
		settle();
		rd("control", `LVD_ADR_CTRL, 32'h84);
		chk("source out", {31'h0, src}, 32'h1);
		ext_low <= 1'b1;
		settle();
		rd("control", `LVD_ADR_CTRL, 32'h85);
		wr(`LVD_ADR_IRQ, 8'h00);
		wr(`LVD_ADR_CTRL, 8'h00);
		rd("request", `LVD_ADR_IRQ, 32'h02);
		rd("control", `LVD_ADR_CTRL, 32'h00);
		wr(`LVD_ADR_IRQ, 8'h00);
		ext_low <= 1'b0;
		settle();
		rd("request", `LVD_ADR_IRQ, 32'h00);
		rd("unmapped", 5'h14, 32'h00);
		$display("test source_and_stop done");
		complete_run();
	end
endmodule
`default_nettype wire

// File: verification/lvd_cmp_model.sv
`timescale 1ns/1ps
`default_nettype none
// ====================================
// Analog comparator pair in front of the detector
module lvd_cmp_model
(
	input  wire logic       detect_enable,
	input  wire logic [3:0] level_code,
	input  wire logic [3:0] supply_lvl,
	input  wire logic       ext_low,
	output logic            cmp_supply_below,
	output logic            cmp_ext_below
);
	// A powered-down comparator reads as above, so a disabled detector never trips.
	// The supply compares against the selected code, so a wrong code shows up here.
	assign cmp_supply_below = detect_enable & (supply_lvl < level_code);
	assign cmp_ext_below    = detect_enable & ext_low;
endmodule
`default_nettype wire

// File: verilog/lvd_ctrl.sv
// Design decisions made here: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "lvd_cfg.svh"

// What this block does
// RULE1: Software masks the interrupt before enabling.
// RULE2: Control bit 2 picks supply or pin.
// RULE3: Control bit 1 picks interrupt or reset.
// RULE4: Level register bits 3..0 set threshold.
// RULE5: Control bit 7 enables detection.
// RULE6: Software waits 410 us after enabling.
// RULE7: Crossings must last 200 us to count.
// RULE8: Control bit 0 shows below-threshold level.
// RULE9: Software enables, clears request, then unmasks.
// RULE10: Request flag bit 1, software may clear.
// RULE11: Stop by writing zero or clearing bits.
// RULE12: Disabling while below raises a request.
// RULE13: Every reset sets the interrupt mask.
// RULE14: Default start loads enable, level 0eh, reset.
// RULE15: Default start when strap bit 0 low.
// RULE16: Any reset re-enables under default start.
// RULE17: Threshold change may raise a request.
// RULE18: Reset cause may read set at power-on.
// RULE19: Software leaves reset mode before unmasking.
// RULE20: Interrupt mode requests on both crossings.
// RULE21: Reset mode holds reset while below.
// RULE22: Comparator passes two flip-flops first.
module lvd_ctrl
#(
	parameter int unsigned MIN_PULSE_CYC = `LVD_MIN_PULSE_US * `LVD_CLK_MHZ
)
(
	input  wire logic                  CORE_CLK,
	input  wire logic                  RST_N,
	input  wire logic                  WB_CYC_I,
	input  wire logic                  WB_STB_I,
	input  wire logic                  WB_WE_I,
	input  wire logic [`LVD_ADR_W-1:0] WB_ADR_I,
	input  wire logic [3:0]            WB_SEL_I,
	input  wire logic [31:0]           WB_DAT_I,
	output logic      [31:0]           WB_DAT_O,
	output logic                       WB_ACK_O,
	input  wire logic                  CMP_SUPPLY_BELOW,
	input  wire logic                  CMP_EXT_BELOW,
	input  wire logic                  DEFAULT_START_DISABLE,
	output logic                       DETECT_ENABLE,
	output logic                       SOURCE_SELECT,
	output logic      [3:0]            LEVEL_CODE,
	output logic                       DETECT_IRQ,
	output logic                       LV_RESET_REQ
);

	// =================================================================
	// Declarations
	logic                en_r;
	logic                src_r;
	logic                mode_r;
	logic [3:0]          level_r;
	logic                irq_req_r;
	logic                irq_req_nxt;
	logic                mask_r;
	logic                cause_r;
	logic                irq_out_r;
	logic                rst_req_r;
	logic                ack_r;
	logic [31:0]         rdata_r;
	logic                ds_sync1_r;
	logic                ds_sync2_r;
	logic                req;
	logic                take;
	logic                wr_lane;
	logic                wr_ctrl;
	logic                wr_level;
	logic                wr_irq;
	logic                wr_mask;
	logic                rd_cause;
	logic                evt;
	logic                wr_src;
	logic [3:0]          wr_lvl;
	lvd_pkg::lvd_byte_t  wdat;
	lvd_pkg::lvd_byte_t  rd_byte;

	lvd_det_if det ();

	// Address match, used by every register decode.
	function automatic logic lvd_hit(
		input logic [`LVD_ADR_W-1:0] adr,
		input logic [`LVD_ADR_W-1:0] off
	);
		lvd_hit = adr == off;
	endfunction

	// =================================================================
	// Strap synchroniser
	// The default-start strap comes from the configuration store, not
	// this clock, so it is retimed before any reset branch looks at it.
	always_ff @(posedge CORE_CLK)
	begin
		ds_sync1_r <= DEFAULT_START_DISABLE;
		ds_sync2_r <= ds_sync1_r;
	end

	// =================================================================
	// Bus decode
	// A write lands at the edge where the master sees ack, never before.
	assign req      = WB_CYC_I && WB_STB_I;
	assign take     = req && ack_r;
	assign wdat     = WB_DAT_I[7:0];
	assign wr_lane  = take && WB_WE_I && WB_SEL_I[0];
	assign wr_ctrl  = wr_lane && lvd_hit(WB_ADR_I, `LVD_ADR_CTRL);
	assign wr_level = wr_lane && lvd_hit(WB_ADR_I, `LVD_ADR_LEVEL);
	assign wr_irq   = wr_lane && lvd_hit(WB_ADR_I, `LVD_ADR_IRQ);
	assign wr_mask  = wr_lane && lvd_hit(WB_ADR_I, `LVD_ADR_MASK);
	assign rd_cause = take && !WB_WE_I && lvd_hit(WB_ADR_I, `LVD_ADR_CAUSE);
	assign wr_src   = wdat[`LVD_BIT_SRC];
	assign wr_lvl   = wdat[`LVD_LEVEL_MSB:0];

	// Single-cycle ack: one wait state, dropped the cycle after it.
	always_ff @(posedge CORE_CLK)
	begin
		if (!RST_N)
			ack_r <= 1'b0;
		else
			ack_r <= req && !ack_r;
	end

	// Read multiplexer; unmapped addresses and reserved bits read zero.
	always_comb
	begin
		rd_byte = `LVD_BYTE_ZERO;
		if (lvd_hit(WB_ADR_I, `LVD_ADR_CTRL))
		begin
			rd_byte[`LVD_BIT_EN]    = en_r;
			rd_byte[`LVD_BIT_SRC]   = src_r;
			rd_byte[`LVD_BIT_MODE]  = mode_r;
			rd_byte[`LVD_BIT_BELOW] = det.below; // RULE8
		end
		else if (lvd_hit(WB_ADR_I, `LVD_ADR_LEVEL))
			rd_byte[`LVD_LEVEL_MSB:0] = level_r;
		else if (lvd_hit(WB_ADR_I, `LVD_ADR_IRQ))
			rd_byte[`LVD_BIT_IRQ] = irq_req_r;
		else if (lvd_hit(WB_ADR_I, `LVD_ADR_MASK))
			rd_byte[`LVD_BIT_MASK] = mask_r;
		else if (lvd_hit(WB_ADR_I, `LVD_ADR_CAUSE))
			rd_byte[`LVD_BIT_CAUSE] = cause_r;
	end

	// Read data is captured in the cycle before ack and held with it.
	always_ff @(posedge CORE_CLK)
	begin
		if (!RST_N)
			rdata_r <= '0;
		else if (req && !ack_r)
			rdata_r <= {`LVD_PAD_ZERO, rd_byte};
	end

	// =================================================================
	// Detector control
	// Under default start every reset, whatever its cause, re-arms the
	// detector in reset mode at once; there is no stabilisation wait.
	always_ff @(posedge CORE_CLK)
	begin
		if (!RST_N)
		begin
			if (!ds_sync2_r) // RULE15
			begin
				en_r    <= 1'b1; // RULE14 RULE16
				src_r   <= 1'b0;
				mode_r  <= 1'b1;
				level_r <= `LVD_LEVEL_DEFAULT;
			end
			else
			begin
				en_r    <= 1'b0;
				src_r   <= 1'b0;
				mode_r  <= 1'b0;
				level_r <= `LVD_LEVEL_RESET;
			end
		end
		else
		begin
			if (wr_ctrl) // RULE11
			begin
				en_r   <= wdat[`LVD_BIT_EN]; // RULE5
				src_r  <= wr_src; // RULE2
				mode_r <= wdat[`LVD_BIT_MODE]; // RULE3
			end
			if (wr_level)
				level_r <= wr_lvl; // RULE4
		end
	end

	// The comparator pair is muxed before the filter's synchroniser.
	assign det.enable    = en_r;
	assign det.raw_below = src_r ? CMP_EXT_BELOW : CMP_SUPPLY_BELOW; // RULE2

	lvd_filter #(
		.MIN_PULSE_CYC (MIN_PULSE_CYC)
	) u_filter (
		.clk   (CORE_CLK),
		.rst_n (RST_N),
		.det   (det)
	);

	// =================================================================
	// Interrupt request
	// Events: a filtered crossing in interrupt mode, switching off while
	// below, or moving the threshold while running. A new event beats a
	// clearing write in the same cycle so no crossing is lost.
	assign evt = (det.changed && en_r && !mode_r) // RULE20
		|| (wr_ctrl && !wdat[`LVD_BIT_EN] && en_r && det.below) // RULE12
		|| (wr_level && en_r && wr_lvl != level_r); // RULE17

	always_comb
	begin
		irq_req_nxt = irq_req_r;
		if (wr_irq)
			irq_req_nxt = wdat[`LVD_BIT_IRQ]; // RULE10
		if (evt)
			irq_req_nxt = 1'b1;
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (!RST_N)
			irq_req_r <= 1'b0;
		else
			irq_req_r <= irq_req_nxt;
	end

	// Mask comes up set so start-up glitches stay hidden.
	always_ff @(posedge CORE_CLK)
	begin
		if (!RST_N)
			mask_r <= 1'b1; // RULE13
		else if (wr_mask)
			mask_r <= wdat[`LVD_BIT_MASK];
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (!RST_N)
			irq_out_r <= 1'b0;
		else
			irq_out_r <= irq_req_r && !mask_r;
	end

	// =================================================================
	// Internal reset and its cause
	// Reset follows the filtered level, so it asserts and releases only
	// after a full-width crossing or a control write that changes the enable
	// or mode bit; the flag is only valid while enabled.
	always_ff @(posedge CORE_CLK)
	begin
		if (!RST_N)
			rst_req_r <= 1'b0;
		else
			rst_req_r <= en_r && mode_r && det.below; // RULE21 RULE3
	end

	// Cleared by reading; a new reset request wins over the read. Under
	// default start a slow supply ramp may already set it.
	always_ff @(posedge CORE_CLK)
	begin
		if (!RST_N)
			cause_r <= 1'b0;
		else if (rst_req_r)
			cause_r <= 1'b1; // RULE18
		else if (rd_cause)
			cause_r <= 1'b0;
	end

	// =================================================================
	// Outputs
	assign WB_ACK_O      = ack_r;
	assign WB_DAT_O      = rdata_r;
	assign DETECT_ENABLE = en_r;
	assign SOURCE_SELECT = src_r;
	assign LEVEL_CODE    = level_r;
	assign DETECT_IRQ    = irq_out_r;
	assign LV_RESET_REQ  = rst_req_r;

	// =================================================================
	// Checks
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);

	sequence s_edge_int;
		det.changed && en_r && !mode_r;
	endsequence

	sequence s_off_below;
		wr_ctrl && !wdat[`LVD_BIT_EN] && en_r && det.below;
	endsequence

	property p_reset_mask;
		$rose(RST_N) |-> mask_r;
	endproperty
	a_reset_mask: assert property (p_reset_mask) else $error("mask clear after reset"); // RULE13

	property p_default_start;
		$rose(RST_N) && !ds_sync2_r |-> en_r && mode_r && !src_r
			&& level_r == `LVD_LEVEL_DEFAULT && !det.below;
	endproperty
	a_default_start: assert property (p_default_start) else $error("bad default start"); // RULE14

	property p_edge_irq;
		s_edge_int ##1 !mask_r |=> DETECT_IRQ;
	endproperty
	a_edge_irq: assert property (p_edge_irq) else $error("crossing gave no irq"); // RULE20

	property p_off_below;
		s_off_below |=> irq_req_r;
	endproperty
	a_off_below: assert property (p_off_below) else $error("disable below no request"); // RULE12

	property p_irq_clear;
		wr_irq && !wdat[`LVD_BIT_IRQ] && !evt |=> !irq_req_r;
	endproperty
	a_irq_clear: assert property (p_irq_clear) else $error("request not cleared"); // RULE10

	property p_reset_mode;
		en_r && mode_r && det.below |=> LV_RESET_REQ;
	endproperty
	a_reset_mode: assert property (p_reset_mode) else $error("no reset while below"); // RULE21

	property p_irq_mode;
		!mode_r |=> !LV_RESET_REQ;
	endproperty
	a_irq_mode: assert property (p_irq_mode) else $error("reset in interrupt mode"); // RULE3

	property p_off_flag;
		!en_r [*2] |-> !det.below;
	endproperty
	a_off_flag: assert property (p_off_flag) else $error("flag set while off"); // RULE5

	property p_src_write;
		wr_ctrl |=> SOURCE_SELECT == $past(wr_src);
	endproperty
	a_src_write: assert property (p_src_write) else $error("source not written"); // RULE2

	property p_level_write;
		wr_level |=> LEVEL_CODE == $past(wr_lvl);
	endproperty
	a_level_write: assert property (p_level_write) else $error("level not written"); // RULE4

	property p_flag_read;
		req && !ack_r && !WB_WE_I && lvd_hit(WB_ADR_I, `LVD_ADR_CTRL)
			|=> WB_DAT_O[`LVD_BIT_BELOW] == $past(det.below);
	endproperty
	a_flag_read: assert property (p_flag_read) else $error("flag read wrong"); // RULE8

endmodule
`default_nettype wire

// File: verilog/lvd_filter.sv
`timescale 1ns/1ps
`default_nettype none
module lvd_filter
#(
	parameter int unsigned MIN_PULSE_CYC = 10000
)
(
	input  wire logic clk,
	input  wire logic rst_n,
	lvd_det_if.filt   det
);

	localparam int unsigned CNT_W = $clog2(MIN_PULSE_CYC + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(MIN_PULSE_CYC - 1);

	logic                    sync1_r;
	logic                    sync2_r;
	lvd_pkg::lvd_filt_state_t state_r;
	logic [CNT_W-1:0]        cnt_r;
	logic                    changed_r;
	logic                    differs;

	// =================================================================
	// Synchroniser
	// The comparator is asynchronous; only the second stage is read.
	always_ff @(posedge clk)
	begin
		sync1_r <= det.raw_below; // RULE22
		sync2_r <= sync1_r;
	end

	assign differs = sync2_r != (state_r == lvd_pkg::LVD_BELOW);

	// =================================================================
	// Pulse-width filter
	// A crossing must hold for the full count; any bounce restarts it.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_r   <= lvd_pkg::LVD_IDLE;
			cnt_r     <= '0;
			changed_r <= 1'b0;
		end
		else
		begin
			changed_r <= 1'b0;
			case (state_r)
				lvd_pkg::LVD_IDLE:
				begin
					cnt_r <= '0;
					if (det.enable)
						state_r <= lvd_pkg::LVD_ABOVE;
				end
				lvd_pkg::LVD_ABOVE, lvd_pkg::LVD_BELOW:
				begin
					if (!det.enable)
					begin
						state_r <= lvd_pkg::LVD_IDLE;
						cnt_r   <= '0;
					end
					else if (differs && cnt_r == CNT_LAST) // RULE7
					begin
						state_r   <= (state_r == lvd_pkg::LVD_BELOW) ?
							lvd_pkg::LVD_ABOVE : lvd_pkg::LVD_BELOW;
						cnt_r     <= '0;
						changed_r <= 1'b1;
					end
					else if (differs)
						cnt_r <= cnt_r + 1'b1;
					else
						cnt_r <= '0;
				end
				default:
				begin
					state_r <= lvd_pkg::LVD_IDLE;
					cnt_r   <= '0;
				end
			endcase
		end
	end

	assign det.below   = state_r == lvd_pkg::LVD_BELOW;
	assign det.changed = changed_r;

	// =================================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_min_pulse;
		det.enable && $past(det.enable) && $changed(det.below) |-> $past(cnt_r) == CNT_LAST;
	endproperty
	a_min_pulse: assert property (p_min_pulse) else $error("level moved before full width"); // RULE7

endmodule
`default_nettype wire
